/* common/sbtc_pkg.sv */
/*
 package of the sixteen-bit timer/counter: register offsets, control field
 positions, prescale encodings and reset values.
 assumes a plain register port with one-cycle read latency.
*/
package sbtc_pkg;
   // register offsets on the plain port (8-bit data)
   localparam logic [2:0] ADDR_COUNT_LOW = 3'h0;
   localparam logic [2:0] ADDR_COUNT_HIGH = 3'h1;
   localparam logic [2:0] ADDR_CONTROL = 3'h2;
   localparam logic [2:0] ADDR_FLAG = 3'h3;
   localparam logic [2:0] ADDR_ENABLE = 3'h4;
   localparam logic [2:0] ADDR_PORT_DIR = 3'h5;
   localparam logic [2:0] ADDR_PORT_DATA = 3'h6;
   // control register field positions
   localparam int CTL_ON = 0;
   localparam int CTL_SRC = 1;
   localparam int CTL_SYNC_BYP = 2;
   localparam int CTL_OSC_EN = 3;
   localparam int CTL_PS_LO = 4;
   localparam int CTL_PS_HI = 5;
   localparam logic [7:0] CTL_MASK = 8'h3f;
   // flag and enable register bit positions
   localparam int FLAG_OVF = 0;
   localparam int EN_OVF = 0;
   localparam int EN_PERIPH = 1;
   localparam int EN_GLOBAL = 2;
   // port bits shared with the crystal pins
   localparam int PORT_BIT_ONE = 1;
   localparam int PORT_BIT_TWO = 2;
   // prescale encodings
   localparam logic [1:0] PS_DIV1 = 2'h0;
   localparam logic [1:0] PS_DIV2 = 2'h1;
   localparam logic [1:0] PS_DIV4 = 2'h2;
   localparam logic [1:0] PS_DIV8 = 2'h3;
   // instruction cycle is four oscillator clocks
   localparam logic [1:0] CYCLE_LAST = 2'h3;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] RST_PORT_DIR = 8'hff;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] COUNT_ALL_ONE = 16'hffff;
endpackage : sbtc_pkg

/* logic/sbtc_sync2.sv */
/*
 two-flip-flop synchroniser for one level.
 assumes the input may come from any clock domain.
*/
`timescale 1ns/10ps
module sbtc_sync2 (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic async_in,
   output logic sync_out
);
   logic meta_q;

   // first stage is read only by the second
   always_ff @(posedge core_clk) begin
      if (rst) begin
         meta_q <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : sbtc_sync2

/* logic/sbtc_timer.sv */
/*
 sixteen-bit timer/counter with prescaler, external count pin, crystal
 oscillator control, overflow flag and wake request.
 assumes core_clk is the oscillator clock (instruction cycle = 4 clocks), a
 synchronous active-high reset, and a plain register port.
 the count pin and the port pins are asynchronous and are synchronised here;
 sleep_mode comes from logic on the same clock.
*/
`timescale 1ns/10ps
module sbtc_timer (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic external_count_clock_pin,
   input wire logic sleep_mode,
   input wire logic [7:0] port_pins_in,
   output logic crystal_osc_run,
   output logic timebase_valid,
   output logic [15:0] timebase_count,
   output logic cpu_irq,
   output logic wake_req
);
   logic [7:0] count_low_byte_q;
   logic [7:0] count_high_byte_q;
   logic [7:0] control_q;
   logic overflow_flag_q;
   logic [2:0] enable_q;
   logic [7:0] port_dir_q;
   logic [1:0] phase_q;
   logic [2:0] prescale_q;
   logic pin_sync;
   logic pin_prev_q;
   logic fall_seen_q;
   logic on_prev_q;
   logic wr_count;
   logic counter_on_bit;
   logic count_source_select;
   logic sync_bypass_control;
   logic crystal_osc_enable;
   logic [1:0] prescale_select_field;
   logic async_mode;
   logic src_tick;
   logic pre_tick;
   logic run;
   logic inc;
   logic [15:0] count_now;
   logic [15:0] count_next;
   logic [7:0] port_dir_view;
   logic [7:0] port_data_view;
   logic [7:0] port_pins_sync;
   logic pin_at_stop_q;
   logic ran_before_q;
   logic rearm_on_start;

   assign counter_on_bit = control_q[sbtc_pkg::CTL_ON];
   assign count_source_select = control_q[sbtc_pkg::CTL_SRC];
   assign sync_bypass_control = control_q[sbtc_pkg::CTL_SYNC_BYP];
   assign crystal_osc_enable = control_q[sbtc_pkg::CTL_OSC_EN];
   assign prescale_select_field = control_q[sbtc_pkg::CTL_PS_HI:sbtc_pkg::CTL_PS_LO];
   assign wr_count = reg_wr && (reg_addr == sbtc_pkg::ADDR_COUNT_LOW || reg_addr == sbtc_pkg::ADDR_COUNT_HIGH);
   assign count_now = {count_high_byte_q, count_low_byte_q};
   // both external modes share one synchroniser, so a mode switch drops or adds no count
   assign async_mode = count_source_select && sync_bypass_control;

   // pin passes two flip-flops before any use
   sbtc_sync2 u_pin_sync (
      .core_clk(core_clk),
      .rst(rst),
      .async_in(external_count_clock_pin),
      .sync_out(pin_sync)
   );

   // port levels come from pins, so each bit passes two flip-flops too
   for (genvar gi = 0; gi < 8; gi++) begin : g_port_sync
      sbtc_sync2 u_port_sync (
         .core_clk(core_clk),
         .rst(rst),
         .async_in(port_pins_in[gi]),
         .sync_out(port_pins_sync[gi])
      );
   end

   // instruction-cycle phase: one tick every four oscillator clocks
   always_ff @(posedge core_clk) begin
      if (rst) begin
         phase_q <= 2'h0;
      end else begin
         phase_q <= phase_q + 2'h1;
      end
   end

   // previous synchronised pin level, for edge detection
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pin_prev_q <= 1'b0; // a rise seen right after reset is harmless: the arm starts clear
      end else begin
         pin_prev_q <= pin_sync;
      end
   end

   // previous on bit, to see the counter being started or stopped
   always_ff @(posedge core_clk) begin
      if (rst) begin
         on_prev_q <= 1'b0;
      end else begin
         on_prev_q <= counter_on_bit;
      end
   end

   // pin level at the last stop of the counter
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pin_at_stop_q <= 1'b0;
      end else if (on_prev_q && !counter_on_bit) begin
         pin_at_stop_q <= pin_sync;
      end
   end

   // remembers that the counter has run since reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ran_before_q <= 1'b0;
      end else if (counter_on_bit) begin
         ran_before_q <= 1'b1;
      end
   end

   // a start needs a fresh fall when it is the first since reset, or when the
   // pin was high at the stop and is low now (its fall went by while stopped)
   assign rearm_on_start = counter_on_bit && !on_prev_q && (!ran_before_q || (pin_at_stop_q && !pin_sync));

   // falling-edge arm: cleared by a count write or a rearming start
   always_ff @(posedge core_clk) begin
      if (rst) begin
         fall_seen_q <= 1'b0;
      end else if (wr_count || rearm_on_start) begin
         fall_seen_q <= 1'b0;
      end else if (pin_prev_q && !pin_sync) begin
         fall_seen_q <= 1'b1;
      end
   end

   // count source: internal cycle or armed rising pin edge
   always_comb begin
      if (count_source_select) begin
         src_tick = fall_seen_q && pin_sync && !pin_prev_q;
      end else begin
         src_tick = (phase_q == sbtc_pkg::CYCLE_LAST);
      end
   end

   // counter runs when on, and in sleep only in async mode
   // every other mode freezes while the device sleeps
   assign run = counter_on_bit && (!sleep_mode || async_mode);

   // prescaler selects its tap per encoding
   // the prescale counter sees raw ticks; a tap fires on every nth one
   always_comb begin
      case (prescale_select_field)
         sbtc_pkg::PS_DIV1: pre_tick = src_tick;
         sbtc_pkg::PS_DIV2: pre_tick = src_tick && prescale_q[0];
         sbtc_pkg::PS_DIV4: pre_tick = src_tick && (&prescale_q[1:0]);
         sbtc_pkg::PS_DIV8: pre_tick = src_tick && (&prescale_q);
         default: pre_tick = src_tick;
      endcase
   end
   assign inc = run && pre_tick;
   assign count_next = count_now + 16'h0001;

   // prescale counter, hidden from software
   always_ff @(posedge core_clk) begin
      if (rst) begin
         prescale_q <= 3'h0;
      end else if (wr_count) begin
         prescale_q <= 3'h0;
      end else if (run && src_tick) begin
         prescale_q <= prescale_q + 3'h1;
      end
   end

   // counter bytes: a software write wins over an increment
   // a colliding increment is dropped, so software should stop the counter first
   always_ff @(posedge core_clk) begin
      if (rst) begin
         count_low_byte_q <= sbtc_pkg::RST_BYTE;
         count_high_byte_q <= sbtc_pkg::RST_BYTE;
      end else if (wr_count) begin
         if (reg_addr == sbtc_pkg::ADDR_COUNT_LOW) begin
            count_low_byte_q <= reg_wdata;
         end else begin
            count_high_byte_q <= reg_wdata;
         end
      end else if (inc) begin
         count_low_byte_q <= count_next[7:0];
         count_high_byte_q <= count_next[15:8];
      end
   end

   // control register: bits 7:6 are not implemented and read zero
   always_ff @(posedge core_clk) begin
      if (rst) begin
         control_q <= sbtc_pkg::RST_BYTE;
      end else if (reg_wr && reg_addr == sbtc_pkg::ADDR_CONTROL) begin
         control_q <= reg_wdata & sbtc_pkg::CTL_MASK;
      end
   end

   // enable register: overflow, peripheral and global interrupt enables
   always_ff @(posedge core_clk) begin
      if (rst) begin
         enable_q <= 3'(sbtc_pkg::RST_BYTE);
      end else if (reg_wr && reg_addr == sbtc_pkg::ADDR_ENABLE) begin
         enable_q <= reg_wdata[sbtc_pkg::EN_GLOBAL:sbtc_pkg::EN_OVF];
      end
   end

   // port direction latch; the crystal override acts on the read view only
   always_ff @(posedge core_clk) begin
      if (rst) begin
         port_dir_q <= sbtc_pkg::RST_PORT_DIR;
      end else if (reg_wr && reg_addr == sbtc_pkg::ADDR_PORT_DIR) begin
         port_dir_q <= reg_wdata;
      end
   end

   // overflow flag: rollover set wins over a software clear
   // software writes the flag with a direct value; hardware never clears it
   always_ff @(posedge core_clk) begin
      if (rst) begin
         overflow_flag_q <= 1'b0;
      end else if (inc && !wr_count && count_now == sbtc_pkg::COUNT_ALL_ONE) begin
         overflow_flag_q <= 1'b1;
      end else if (reg_wr && reg_addr == sbtc_pkg::ADDR_FLAG) begin
         overflow_flag_q <= reg_wdata[sbtc_pkg::FLAG_OVF];
      end
   end

   // crystal pins force direction to input and data to zero
   always_comb begin
      port_dir_view = port_dir_q;
      port_data_view = port_pins_sync;
      if (crystal_osc_enable) begin
         port_dir_view[sbtc_pkg::PORT_BIT_ONE] = 1'b1;
         port_dir_view[sbtc_pkg::PORT_BIT_TWO] = 1'b1;
         port_data_view[sbtc_pkg::PORT_BIT_ONE] = 1'b0;
         port_data_view[sbtc_pkg::PORT_BIT_TWO] = 1'b0;
      end
   end

   // read data one cycle after the strobe; unmapped reads zero
   // reads have no side effects, so a two-byte read may simply be repeated
   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_rdata <= sbtc_pkg::RST_BYTE;
      end else if (reg_rd) begin
         case (reg_addr)
            sbtc_pkg::ADDR_COUNT_LOW: reg_rdata <= count_low_byte_q;
            sbtc_pkg::ADDR_COUNT_HIGH: reg_rdata <= count_high_byte_q;
            sbtc_pkg::ADDR_CONTROL: reg_rdata <= control_q;
            sbtc_pkg::ADDR_FLAG: reg_rdata <= {7'h00, overflow_flag_q};
            sbtc_pkg::ADDR_ENABLE: reg_rdata <= {5'h00, enable_q};
            sbtc_pkg::ADDR_PORT_DIR: reg_rdata <= port_dir_view;
            sbtc_pkg::ADDR_PORT_DATA: reg_rdata <= port_data_view;
            default: reg_rdata <= sbtc_pkg::RST_BYTE;
         endcase
      end else begin
         reg_rdata <= sbtc_pkg::RST_BYTE;
      end
   end

   // oscillator run request follows the enable bit, sleep or not
   always_ff @(posedge core_clk) begin
      if (rst) begin
         crystal_osc_run <= 1'b0;
      end else begin
         crystal_osc_run <= crystal_osc_enable;
      end
   end

   // capture/compare may use the time base only outside async counting
   always_ff @(posedge core_clk) begin
      if (rst) begin
         timebase_valid <= 1'b0;
      end else begin
         timebase_valid <= !async_mode;
      end
   end

   // time base copy of the counter, one cycle late
   always_ff @(posedge core_clk) begin
      if (rst) begin
         timebase_count <= sbtc_pkg::COUNT_ZERO;
      end else begin
         timebase_count <= count_now;
      end
   end

   // processor interrupt needs the flag and all three enables
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cpu_irq <= 1'b0;
      end else begin
         cpu_irq <= overflow_flag_q && (&enable_q);
      end
   end

   // wake request: overflow in async sleep with overflow and peripheral enables
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wake_req <= 1'b0;
      end else begin
         wake_req <= sleep_mode && async_mode && overflow_flag_q && enable_q[sbtc_pkg::EN_OVF]
            && enable_q[sbtc_pkg::EN_PERIPH];
      end
   end
endmodule : sbtc_timer

/* bench/sbtc_timer_properties.sv */
/*
 checker for the timer/counter top ports.
 assumes rst is synchronous and a counter write reaches timebase_count two cycles later.
*/
`timescale 1ns/10ps
module sbtc_timer_properties (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic sleep_mode,
   input wire logic crystal_osc_run,
   input wire logic timebase_valid,
   input wire logic [15:0] timebase_count,
   input wire logic cpu_irq,
   input wire logic wake_req
);
   logic [2:0] busy_q;
   // recent writes or resets that may move the count
   always_ff @(posedge core_clk) begin
      busy_q <= {busy_q[1:0], reg_wr | rst};
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
   a_count_step: assert property (busy_q == 3'h0 |-> timebase_count == $past(timebase_count)
      || timebase_count == $past(timebase_count) + 16'h1) else $error("count jumped");
   a_tick_rate: assert property ((timebase_count == $past(timebase_count) + 16'h1 && busy_q == 3'h0)
      ##1 !busy_q[0] |-> $stable(timebase_count) ##1 $stable(timebase_count)) else $error("count too fast");
   a_osc_follow: assert property ((reg_wr && reg_addr == sbtc_pkg::ADDR_CONTROL) ##1 !reg_wr
      |=> crystal_osc_run == $past(reg_wdata[sbtc_pkg::CTL_OSC_EN], 2)) else $error("oscillator bit lost");
   a_irq_cause: assert property ($rose(cpu_irq) |-> busy_q[1:0] != 2'h0
      || ($past(timebase_count) == 16'hffff && timebase_count == 16'h0000)) else $error("interrupt without cause");
   a_irq_hold: assert property ($fell(cpu_irq) |-> busy_q[1:0] != 2'h0) else $error("interrupt dropped");
   a_wake_sleep: assert property (wake_req |-> $past(sleep_mode)) else $error("wake while awake");
   a_sleep_freeze: assert property ((sleep_mode && timebase_valid && busy_q == 3'h0 && !reg_wr)
      ##1 (sleep_mode && !reg_wr) [*3] |=> $stable(timebase_count)) else $error("count ran in sleep");
   c_irq: cover property ($rose(cpu_irq));
   c_wake: cover property ($rose(wake_req));
   c_async: cover property ($fell(timebase_valid));
endmodule : sbtc_timer_properties

bind sbtc_timer sbtc_timer_properties i_sbtc_timer_properties (.core_clk(core_clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .sleep_mode(sleep_mode), .crystal_osc_run(crystal_osc_run), .timebase_valid(timebase_valid),
   .timebase_count(timebase_count), .cpu_irq(cpu_irq), .wake_req(wake_req));

/* bench/sbtc_ext_src.sv */
/*
 external count clock source on the count pin.
 assumes the bench calls pulse; the pin stands low between bursts.
*/
`timescale 1ns/10ps
module sbtc_ext_src #(parameter int HALF_NS = 1000) (
   output logic pin
);
   initial pin = 1'b0;
   // n full periods, rising edge first, ending low
   task automatic pulse(input int n);
      #(HALF_NS / 40); // keeps every pin change off the clock edges
      for (int i = 0; i < n; i++) begin
         pin = 1'b1;
         #(HALF_NS);
         pin = 1'b0;
         #(HALF_NS);
      end
   endtask : pulse
endmodule : sbtc_ext_src

/* bench/testbench.sv */
/*
 self-checking bench for the timer/counter over its register port.
 assumes the clock source model drives the count pin.
*/
`timescale 1ns/10ps
module testbench;
   logic core_clk, rst, reg_wr, reg_rd, sleep_mode, ext_pin, crystal_osc_run, timebase_valid, cpu_irq, wake_req;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, port_pins_in;
   logic [15:0] timebase_count;
   int failures = 0;
   int samples_checked = 0;
   int cycles = 0;
   sbtc_timer i_sbtc_timer (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .external_count_clock_pin(ext_pin),
      .sleep_mode(sleep_mode), .port_pins_in(port_pins_in), .crystal_osc_run(crystal_osc_run),
      .timebase_valid(timebase_valid), .timebase_count(timebase_count), .cpu_irq(cpu_irq), .wake_req(wake_req));
   sbtc_ext_src i_sbtc_ext_src (.pin(ext_pin));
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      samples_checked++;
      if (s !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic w(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : w
   task automatic r(input logic [2:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      chk($sformatf("reg %0d", a), 16'(reg_rdata), 16'(e));
   endtask : r
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : print_verdict
   // clock
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         print_verdict();
      end
   end
   // main sequence
   initial begin
      rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      sleep_mode = 1'b0;
      port_pins_in = 8'hff;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      r(sbtc_pkg::ADDR_CONTROL, 8'h00);
      r(sbtc_pkg::ADDR_PORT_DIR, 8'hff);
      r(3'h7, 8'h00);
      $display("test reset done");
      // leftover prescale ticks must be wiped by the counter write
      for (int ps = 3; ps >= 0; ps--) begin
         w(sbtc_pkg::ADDR_COUNT_LOW, 8'h00);
         w(sbtc_pkg::ADDR_COUNT_HIGH, 8'h00);
         w(sbtc_pkg::ADDR_CONTROL, {2'h0, 2'(ps), 4'h1});
         repeat (4 * (6 * (1 << ps) - 1) - 2) @(posedge core_clk);
         w(sbtc_pkg::ADDR_CONTROL, 8'h00);
         repeat (20) @(posedge core_clk);
         r(sbtc_pkg::ADDR_COUNT_LOW, 8'h05);
         chk("timebase", timebase_count, 16'h0005);
      end
      $display("test prescale done");
      w(sbtc_pkg::ADDR_COUNT_LOW, 8'h00);
      w(sbtc_pkg::ADDR_CONTROL, 8'h03);
      i_sbtc_ext_src.pulse(4);
      r(sbtc_pkg::ADDR_COUNT_LOW, 8'h03);
      w(sbtc_pkg::ADDR_CONTROL, 8'h07);
      sleep_mode <= 1'b1;
      i_sbtc_ext_src.pulse(3);
      r(sbtc_pkg::ADDR_COUNT_LOW, 8'h06);
      w(sbtc_pkg::ADDR_CONTROL, 8'h05);
      repeat (40) @(posedge core_clk);
      r(sbtc_pkg::ADDR_COUNT_LOW, 8'h06);
      $display("test external done");
      w(sbtc_pkg::ADDR_CONTROL, 8'h00);
      w(sbtc_pkg::ADDR_COUNT_LOW, 8'h00);
      w(sbtc_pkg::ADDR_COUNT_HIGH, 8'h00);
      w(sbtc_pkg::ADDR_FLAG, 8'h00);
      w(sbtc_pkg::ADDR_ENABLE, 8'h03);
      w(sbtc_pkg::ADDR_COUNT_LOW, 8'hff);
      w(sbtc_pkg::ADDR_COUNT_HIGH, 8'hff);
      w(sbtc_pkg::ADDR_CONTROL, 8'h07);
      i_sbtc_ext_src.pulse(2);
      @(negedge core_clk);
      chk("wake", 16'(wake_req), 16'h1);
      r(sbtc_pkg::ADDR_FLAG, 8'h01);
      r(sbtc_pkg::ADDR_COUNT_HIGH, 8'h00);
      sleep_mode <= 1'b0;
      for (int e = 0; e < 8; e++) begin
         w(sbtc_pkg::ADDR_ENABLE, 8'(e));
         repeat (3) @(negedge core_clk);
         chk("irq", 16'(cpu_irq), 16'(e == 7));
      end
      w(sbtc_pkg::ADDR_FLAG, 8'h00);
      repeat (3) @(negedge core_clk);
      chk("irq", 16'(cpu_irq), 16'h0);
      // stop with the pin low and restart: the next rise counts at once
      w(sbtc_pkg::ADDR_CONTROL, 8'h02);
      w(sbtc_pkg::ADDR_CONTROL, 8'h03);
      i_sbtc_ext_src.pulse(1);
      r(sbtc_pkg::ADDR_COUNT_LOW, 8'h01);
      $display("test overflow done");
      w(sbtc_pkg::ADDR_PORT_DIR, 8'h00);
      w(sbtc_pkg::ADDR_CONTROL, 8'hf8);
      repeat (50) @(posedge core_clk); // start-up wait, core clock taken as internal
      w(sbtc_pkg::ADDR_CONTROL, 8'hff);
      r(sbtc_pkg::ADDR_CONTROL, 8'h3f);
      r(sbtc_pkg::ADDR_PORT_DIR, 8'h06);
      r(sbtc_pkg::ADDR_PORT_DATA, 8'hf9);
      chk("osc", 16'(crystal_osc_run), 16'h1);
      chk("valid", 16'(timebase_valid), 16'h0);
      w(sbtc_pkg::ADDR_CONTROL, 8'h00);
      r(sbtc_pkg::ADDR_PORT_DIR, 8'h00);
      chk("valid", 16'(timebase_valid), 16'h1);
      $display("test crystal done");
      print_verdict();
   end
endmodule : testbench
